// ===== hdl/clock_select_pkg.sv
// constants for the system clock select control block
package clock_select_pkg;
  localparam logic [7:0] clock_control_offset = 8'h00_c6;
  localparam logic [7:0] aux_control_offset = 8'h00_c7;
  localparam logic [7:0] aux_status_offset = 8'h00_c8;
  // clock control field positions
  localparam int lf_sel_bit = 7;
  localparam int sys_sel_bit = 6;
  localparam int tick_lsb = 3;
  localparam int speed_bit = 0;
  // aux control field positions
  localparam int powerdown_bit = 0;
  localparam int cal_dis_bit = 1;
  // reset values
  localparam logic lf_sel_reset = 1'b1;
  localparam logic sys_sel_reset = 1'b1;
  localparam logic [2:0] tick_reset = 3'h1;
  localparam logic speed_reset = 1'b1;
  localparam logic powerdown_reset = 1'b1;
  // settle times of the oscillator models, in ns
  localparam int crystal_settle_ns = 2000;
  localparam int rc_settle_ns = 500;
  localparam int clk_period_ns = 10;
  localparam logic [11:0] crystal_settle_cycles =
    12'((crystal_settle_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [11:0] rc_settle_cycles =
    12'((rc_settle_ns + clk_period_ns - 1) / clk_period_ns);
endpackage

// ===== hdl/system_clock_select_control.sv
// clock source select, tick divider and oscillator power control
// Overview of operation
// - bit 7 picks low-frequency source
// - bit 7 returns to 1 after deep sleep
// - bit 6 requests system source, reset 1
// - switch only once requested oscillator stable
// - requesting powered-down RC powers it up
// - bits 5:3 tick divider, reset 001
// - bit 0 reports current clock speed
// - speed flag changes only after switch
// - calibration disable lets running calibration finish
// - other bits retained through deep sleep
// - crystal stable flag reads 1 when stable
// - power-down bit stops unselected oscillator
`timescale 1ns/100ps
`default_nettype none
module system_clock_select_control (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic deep_sleep_exit,
  input wire logic calibration_request,
  output logic crystal_powered,
  output logic rc_powered,
  output logic sys_clk_on_rc,
  output logic low_freq_on_rc,
  output logic [2:0] timer_tick_divider,
  output logic calibration_busy
);
  import clock_select_pkg::*;

  // all state of the block
  typedef struct packed {
    logic low_freq_source_select;
    logic sys_source_request;
    logic [2:0] tick;
    logic sys_clk_speed_flag;
    logic unselected_osc_powerdown;
    logic rc_lowfreq_cal_disable;
    logic pd_pending; // power-down write held during calibration
    logic pd_pending_val;
    logic [11:0] xtal_cnt;
    logic [11:0] rc_cnt;
    logic cal_busy;
    logic [7:0] rdata;
  } state_type;

  state_type st;
  state_type next_st;
  logic xtal_on; // crystal powered
  logic rc_on; // rc powered
  logic xtal_stable;
  logic rc_stable;
  logic wr_ctl;
  logic wr_aux;

  // oscillator power, derived from active source
  always_comb begin
    // unselected one is off only when power-down bit is set
    xtal_on = !st.sys_clk_speed_flag || !st.unselected_osc_powerdown;
    // a pending rc request turns rc on even when powered down
    rc_on = st.sys_clk_speed_flag || !st.unselected_osc_powerdown
      || st.sys_source_request;
    xtal_stable = xtal_on && (st.xtal_cnt == crystal_settle_cycles);
    rc_stable = rc_on && (st.rc_cnt == rc_settle_cycles);
    wr_ctl = reg_write && (reg_addr == clock_control_offset);
    wr_aux = reg_write && (reg_addr == aux_control_offset);
  end

  // next-state logic
  always_comb begin
    next_st = st;
    // settle counters model oscillator start-up
    if (!xtal_on) begin
      next_st.xtal_cnt = 12'h0_000;
    end else if (!xtal_stable) begin
      next_st.xtal_cnt = st.xtal_cnt + 12'h0_001;
    end
    if (!rc_on) begin
      next_st.rc_cnt = 12'h0_000;
    end else if (!rc_stable) begin
      next_st.rc_cnt = st.rc_cnt + 12'h0_001;
    end
    // switch only once the requested source is stable
    if (st.sys_source_request != st.sys_clk_speed_flag) begin
      if (st.sys_source_request && rc_stable) begin
        next_st.sys_clk_speed_flag = 1'b1;
      end else if (!st.sys_source_request && xtal_stable) begin
        next_st.sys_clk_speed_flag = 1'b0;
      end
    end
    // calibration only starts on a stable crystal, not disabled
    if (calibration_request && !st.cal_busy && xtal_stable
        && !st.rc_lowfreq_cal_disable) begin
      next_st.cal_busy = 1'b1;
    end else if (st.cal_busy && !calibration_request) begin
      next_st.cal_busy = 1'b0;
    end
    // deferred power-down write lands when calibration ends
    if (st.pd_pending && !st.cal_busy) begin
      next_st.unselected_osc_powerdown = st.pd_pending_val;
      next_st.pd_pending = 1'b0;
    end
    // register writes
    if (wr_ctl) begin
      next_st.low_freq_source_select = reg_wdata[lf_sel_bit];
      next_st.sys_source_request = reg_wdata[sys_sel_bit];
      next_st.tick = reg_wdata[tick_lsb +: 3];
      // bits 2:1 and speed bit are not writable
    end
    if (wr_aux) begin
      // disable does not abort a calibration in progress
      next_st.rc_lowfreq_cal_disable = reg_wdata[cal_dis_bit];
      if (st.cal_busy) begin
        next_st.pd_pending = 1'b1;
        next_st.pd_pending_val = reg_wdata[powerdown_bit];
      end else begin
        next_st.unselected_osc_powerdown = reg_wdata[powerdown_bit];
      end
    end
    // deep sleep loses only the low-frequency select
    // placed after the writes so an exit beats a write to bit 7
    if (deep_sleep_exit) begin
      next_st.low_freq_source_select = lf_sel_reset;
    end
    // read data, valid the cycle after the strobe
    next_st.rdata = 8'h0_0;
    if (reg_read) begin
      case (reg_addr)
        clock_control_offset: begin
          next_st.rdata = {st.low_freq_source_select,
            st.sys_source_request, st.tick, 2'b00,
            st.sys_clk_speed_flag};
        end
        aux_control_offset: begin
          next_st.rdata = {6'h0_0, st.rc_lowfreq_cal_disable,
            st.unselected_osc_powerdown};
        end
        aux_status_offset: begin
          next_st.rdata = {5'h0_0, st.cal_busy, rc_stable,
            xtal_stable};
        end
        default: begin
          next_st.rdata = 8'h0_0; // unmapped reads zero
        end
      endcase
    end
  end

  // state register, synchronous reset
  // reset values live in the package so the bench shares them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.low_freq_source_select <= lf_sel_reset;
      st.sys_source_request <= sys_sel_reset;
      st.tick <= tick_reset;
      st.sys_clk_speed_flag <= speed_reset;
      st.unselected_osc_powerdown <= powerdown_reset;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops or power logic
  always_comb begin
    reg_rdata = st.rdata;
    crystal_powered = xtal_on;
    rc_powered = rc_on;
    sys_clk_on_rc = st.sys_clk_speed_flag;
    low_freq_on_rc = st.low_freq_source_select;
    timer_tick_divider = st.tick;
    calibration_busy = st.cal_busy;
  end

  // speed flag never moves to crystal before it is stable
  property p_switch_xtal;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(st.sys_clk_speed_flag) |-> $past(xtal_stable);
  endproperty
  a_switch_xtal: assert property (p_switch_xtal)
    else $error("switched to crystal before stable");

  property p_switch_rc;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.sys_clk_speed_flag) |-> $past(rc_stable);
  endproperty
  a_switch_rc: assert property (p_switch_rc)
    else $error("switched to rc before stable");

  property p_rc_autopower;
    @(posedge ref_clk) disable iff (!rst_n)
    st.sys_source_request |-> rc_on;
  endproperty
  a_rc_autopower: assert property (p_rc_autopower)
    else $error("rc requested but not powered");

  property p_lf_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    deep_sleep_exit |=> st.low_freq_source_select;
  endproperty
  a_lf_reset: assert property (p_lf_reset)
    else $error("low-freq select not restored");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
    reg_read && reg_addr == clock_control_offset
      |=> reg_rdata[2:1] == 2'b00
      && reg_rdata[speed_bit] == $past(st.sys_clk_speed_flag);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("clock control readback wrong");

  property p_tick_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ctl && !deep_sleep_exit |=> timer_tick_divider == $past(reg_wdata[5:3]);
  endproperty
  a_tick_write: assert property (p_tick_write)
    else $error("tick divider not written");

  property p_cal_finish;
    @(posedge ref_clk) disable iff (!rst_n)
    st.cal_busy && calibration_request |=> st.cal_busy;
  endproperty
  a_cal_finish: assert property (p_cal_finish)
    else $error("calibration aborted");

  // running on rc with power-down set keeps the crystal off
  property p_powerdown;
    @(posedge ref_clk) disable iff (!rst_n)
    st.unselected_osc_powerdown && st.sys_clk_speed_flag |-> !xtal_on;
  endproperty
  a_powerdown: assert property (p_powerdown)
    else $error("crystal powered while unselected");

  // running on crystal with power-down set, rc not requested, rc stays off
  property p_powerdown_rc;
    @(posedge ref_clk) disable iff (!rst_n)
    st.unselected_osc_powerdown && !st.sys_clk_speed_flag
      && !st.sys_source_request |-> !rc_on;
  endproperty
  a_powerdown_rc: assert property (p_powerdown_rc)
    else $error("rc powered while unselected");

  // power-down clear keeps both oscillators running
  property p_both_run;
    @(posedge ref_clk) disable iff (!rst_n)
    !st.unselected_osc_powerdown |-> crystal_powered && rc_powered;
  endproperty
  a_both_run: assert property (p_both_run)
    else $error("oscillator off with power-down clear");

  property p_retain;
    @(posedge ref_clk) disable iff (!rst_n)
    deep_sleep_exit && !wr_ctl |=> $stable(st.tick)
      && $stable(st.sys_source_request);
  endproperty
  a_retain: assert property (p_retain)
    else $error("bits lost over deep sleep");

  // a requested rc starts its settle count at once
  property p_rc_counting;
    @(posedge ref_clk) disable iff (!rst_n)
    st.sys_source_request && !st.sys_clk_speed_flag
      |=> st.rc_cnt != 12'h000;
  endproperty
  a_rc_counting: assert property (p_rc_counting)
    else $error("requested rc not starting");

  // speed flag only ever moves towards the requested source
  property p_flag_follows;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(st.sys_clk_speed_flag)
      |-> st.sys_clk_speed_flag == $past(st.sys_source_request);
  endproperty
  a_flag_follows: assert property (p_flag_follows)
    else $error("speed flag moved against request");

  // bit 7 written lands on the low-frequency select
  property p_lf_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ctl && !deep_sleep_exit
      |=> low_freq_on_rc == $past(reg_wdata[lf_sel_bit]);
  endproperty
  a_lf_write: assert property (p_lf_write)
    else $error("low-freq select not written");

  // disable bit set keeps a new calibration from starting
  property p_cal_start;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.cal_busy) |-> !$past(st.rc_lowfreq_cal_disable);
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration started while disabled");
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the clock select control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import clock_select_pkg::*;
  logic ref_clk, rst_n, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic deep_sleep_exit, calibration_request;
  logic crystal_powered, rc_powered, sys_clk_on_rc, low_freq_on_rc;
  logic calibration_busy;
  logic [2:0] timer_tick_divider;
  int errors, cmp_count, i;
  system_clock_select_control system_clock_select_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .deep_sleep_exit(deep_sleep_exit),
    .calibration_request(calibration_request),
    .crystal_powered(crystal_powered), .rc_powered(rc_powered),
    .sys_clk_on_rc(sys_clk_on_rc), .low_freq_on_rc(low_freq_on_rc),
    .timer_tick_divider(timer_tick_divider),
    .calibration_busy(calibration_busy));
  // 100 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // compare and count
  task check(input string name, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  // bounded wait on the source flag (0) or calibration busy (1)
  task wait_for(input int sel, input logic val);
    int n;
    n = 0;
    while (((sel == 0) ? sys_clk_on_rc : calibration_busy) !== val
           && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  // verdict, reached from the tests or the watchdog
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the ~7k cycles the tests need
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    deep_sleep_exit = 1'b0;
    calibration_request = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(clock_control_offset); check("ctl reset", rd_val, 8'hc9);
    check("tick reset", {5'h00, timer_tick_divider}, 8'h01);
    rd(aux_control_offset); check("aux reset", rd_val, 8'h01);
    // crystal asked for while powered down must never take over
    wr(clock_control_offset, 8'h89);
    repeat (400) @(posedge ref_clk);
    check("no switch", {7'h00, sys_clk_on_rc}, 8'h01);
    rd(clock_control_offset); check("speed held", rd_val, 8'h89);
    wr(clock_control_offset, 8'hc9);
    // tick codes 1 to 7 while on the 16 mhz source
    for (i = 1; i < 8; i++) begin
      wr(clock_control_offset, {2'b11, i[2:0], 3'b000});
      check("tick", {5'h00, timer_tick_divider}, 8'(i));
      rd(clock_control_offset);
      check("tick rd", rd_val, {2'b11, i[2:0], 3'b001});
    end
    // reserved and speed bits ignore writes, low source follows bit 7
    wr(clock_control_offset, 8'h5e);
    check("lf crystal", {7'h00, low_freq_on_rc}, 8'h00);
    rd(clock_control_offset); check("reserved", rd_val, 8'h59);
    // deep sleep drops bit 7 only
    @(posedge ref_clk) deep_sleep_exit <= 1'b1;
    @(posedge ref_clk) deep_sleep_exit <= 1'b0;
    rd(clock_control_offset); check("sleep", rd_val, 8'hd9);
    wr(8'h10, 8'hff);
    rd(8'h10); check("unmapped", rd_val, 8'h00);
    rd(clock_control_offset); check("untouched", rd_val, 8'hd9);
    // power the crystal, wait for stable, then the safety time
    wr(aux_control_offset, 8'h00);
    check("xtal on", {7'h00, crystal_powered}, 8'h01);
    rd(aux_status_offset); check("not stable", rd_val & 8'h01, 8'h00);
    i = 0;
    do begin
      rd(aux_status_offset);
      i++;
    end while (rd_val[0] !== 1'b1 && i < 300);
    check("stable", rd_val & 8'h01, 8'h01);
    repeat (6400) @(posedge ref_clk);
    wr(clock_control_offset, 8'h99);
    wait_for(0, 1'b0);
    check("on xtal", {7'h00, sys_clk_on_rc}, 8'h00);
    rd(clock_control_offset); check("speed 32", rd_val, 8'h98);
    wr(clock_control_offset, 8'h80);
    check("tick 32", {5'h00, timer_tick_divider}, 8'h00);
    // disabling calibration lets the running one finish
    @(posedge ref_clk) calibration_request <= 1'b1;
    wait_for(1, 1'b1);
    wr(aux_control_offset, 8'h03);
    repeat (20) @(posedge ref_clk);
    #1;
    check("cal runs", {7'h00, calibration_busy}, 8'h01);
    rd(aux_status_offset); check("status", rd_val, 8'h07);
    rd(aux_control_offset); check("pd held", rd_val, 8'h02);
    @(posedge ref_clk) calibration_request <= 1'b0;
    wait_for(1, 1'b0);
    check("cal done", {7'h00, calibration_busy}, 8'h00);
    rd(aux_control_offset); check("pd landed", rd_val, 8'h03);
    // power-down stops the unselected rc, asking for it restarts it
    wr(aux_control_offset, 8'h01);
    check("rc off", {7'h00, rc_powered}, 8'h00);
    wr(clock_control_offset, 8'hc9);
    check("rc auto on", {7'h00, rc_powered}, 8'h01);
    wait_for(0, 1'b1);
    check("on rc", {7'h00, sys_clk_on_rc}, 8'h01);
    check("xtal off", {7'h00, crystal_powered}, 8'h00);
    rd(clock_control_offset); check("speed 16", rd_val, 8'hc9);
    complete_run();
  end
endmodule
`default_nettype wire
